// File: fwp_pkg.sv
// shared constants and types for the quad flash link, both ends
package fwp_pkg;
	localparam int PCLK_PERIOD_NS = 5;
	localparam int PROG_TIME_NS = 20000;
	localparam int PROG_CYC = PROG_TIME_NS / PCLK_PERIOD_NS;
	localparam int SCK_HALF = 8;
	localparam int PAGE_BYTES = 256;
	localparam logic [7:0] OP_PROG = 8'h02;
	localparam logic [7:0] OP_STATUS = 8'h05;
	localparam logic [7:0] OP_WR_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRAP_SET = 8'h77;
	localparam logic [7:0] OP_WORD_QREAD = 8'hE7;
	localparam logic [7:0] OP_OCTAL_QREAD = 8'hE3;
	localparam logic [7:0] OP_READ_PARAM = 8'hC0;
	localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
	localparam logic [7:0] OP_RESET = 8'h99;
	localparam logic WRAP_DIS_RST = 1'b1;
	localparam logic [1:0] WRAP_LEN_RST = 2'b00;
	localparam logic [1:0] CRM_ARM = 2'b10;
	localparam int WRAP_DIS_POS = 4;
	localparam int WRAP_LEN_LO = 5;
	localparam int CRM_SEL_LO = 4;
	localparam int PARAM_LEN_LO = 0;
	localparam logic [5:0] WORD_DUMMY = 6'h02;
	localparam logic [5:0] ADDR_BITS = 6'h18;
	localparam int STAT_BUSY = 0;
	localparam int STAT_WEL = 1;
	localparam logic [22:0] CHIP_BYTES = 23'h40_0000;
	localparam logic [22:0] SECTOR_BYTES = 23'h00_1000;
	localparam logic [22:0] BLOCK_BYTES = 23'h01_0000;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_MODE = 8'h08;
	localparam logic [7:0] REG_WDATA = 8'h0C;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam int CF_SKIP_OP = 8;
	localparam int CF_ADDR_EN = 9;
	localparam int CF_ADDR_QUAD = 10;
	localparam int CF_MODE_EN = 11;
	localparam int CF_DUMMY_LO = 12;
	localparam int CF_WRITE = 15;
	localparam int CF_DATA_QUAD = 16;
	localparam int CF_NBYTES_LO = 17;
	localparam int CF_START = 31;
	typedef enum logic [3:0] {S_IDLE, S_CMD, S_ADDR, S_MODE, S_DUM, S_DATA, S_PROG, S_STAT,
		S_IGN} fwp_dev_st_t;
	typedef enum logic [2:0] {H_IDLE, H_OP, H_ADDR, H_MODE, H_DUM, H_DATA, H_END} fwp_host_st_t;
endpackage : fwp_pkg

// File: fwp_link_if.sv
// serial link between host controller and flash device
interface fwp_link_if;
	logic cs_n;
	logic sclk;
	logic [3:0] host_io_o;
	logic [3:0] host_io_oe_n;
	logic [3:0] dev_io_o;
	logic [3:0] dev_io_oe_n;
	logic [3:0] io;
	// undriven lines float high, like the board pull-ups
	for (genvar i = 0; i < 4; i++) begin : g_res
		assign io[i] = !host_io_oe_n[i] ? host_io_o[i] : (!dev_io_oe_n[i] ? dev_io_o[i] : 1'b1);
	end
	modport host (output cs_n, output sclk, output host_io_o, output host_io_oe_n, input io);
	modport dev (input cs_n, input sclk, input io, output dev_io_o, output dev_io_oe_n);
endinterface : fwp_link_if

// File: fwp_flash_dev.sv
// flash device end: command decode, quad reads with wrap on the word read only, page program
//
// Added by the designer: the placing of the registers and register access over APB.
module fwp_flash_dev import fwp_pkg::*; #(
	parameter int MEM_BYTES = 4096,
	parameter int PROG_CYCLES = PROG_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	fwp_link_if.dev link,
	input wire logic quad_enable_bit,
	input wire logic four_line_command_mode,
	input wire logic protect_complement_bit,
	input wire logic protect_granularity_bit,
	input wire logic protect_top_bottom_bit,
	input wire logic protect_range_bit2,
	input wire logic protect_range_bit1,
	input wire logic protect_range_bit0,
	input wire logic [63:0] block_lock_map,
	output logic status_busy,
	output logic status_wel,
	output logic wrap_disable_bit,
	output logic [1:0] wrap_length_field,
	output logic continuous_read_armed
);
	localparam int AW = $clog2(MEM_BYTES);

	typedef struct packed {
		fwp_dev_st_t st;
		logic [2:0] ck;
		logic [2:0] cs;
		logic [3:0] io1;
		logic [3:0] io2;
		logic [5:0] cnt;
		logic [31:0] sh;
		logic [7:0] op;
		logic [23:0] addr;
		logic crm;
		logic [7:0] crm_op;
		logic wrap_dis;
		logic [1:0] wrap_len;
		logic write_enable_latch;
		logic busy;
		logic [15:0] tmr;
		logic got;
		logic reset_en;
		logic nib;
		logic [7:0] dbyte;
		logic [3:0] io_o;
		logic [3:0] oe_n;
		logic pw;
		logic [7:0] pw_idx;
		logic [7:0] pw_dat;
		logic [255:0] pval;
		logic [15:0] prog_base;
	} fwp_dev_state_t;

	fwp_dev_state_t s_r;
	fwp_dev_state_t s_nxt;
	logic [7:0] mem [0:MEM_BYTES-1];
	logic [7:0] pbuf [0:PAGE_BYTES-1];
	logic [23:0] commit_addr;

	// next read address, looping inside an aligned section when wrap is on
	function automatic logic [23:0] read_next(logic [23:0] a, logic en, logic [1:0] len);
		logic [23:0] m;
		m = {16'h0000, 8'(8'h08 << len) - 8'h01};
		if (en) begin
			return (a & ~m) | ((a + 24'h00_0001) & m);
		end
		return a + 24'h00_0001;
	endfunction : read_next

	function automatic logic is_protected(logic [23:0] a, logic [2:0] bp, logic cmp, logic sec,
		logic tb, logic [63:0] locks);
		logic [22:0] size;
		logic p;
		size = sec ? (SECTOR_BYTES << (bp - 3'h1)) : (BLOCK_BYTES << (bp - 3'h1));
		if (bp == 3'h0) begin
			p = 1'b0;
		end else if (tb) begin
			p = {1'b0, a[21:0]} < size;
		end else begin
			p = {1'b0, a[21:0]} >= CHIP_BYTES - size;
		end
		return (p ^ cmp) | locks[a[21:16]];
	endfunction : is_protected

	always_comb begin
		logic rise;
		logic fall;
		logic quad;
		logic [31:0] sh_in;
		logic [7:0] b;
		logic [7:0] stat;
		s_nxt = s_r;
		rise = s_r.ck[1] & ~s_r.ck[2];
		fall = ~s_r.ck[1] & s_r.ck[2];
		quad = (s_r.op != OP_PROG);
		sh_in = quad ? {s_r.sh[27:0], s_r.io2} : {s_r.sh[30:0], s_r.io2[0]};
		b = sh_in[7:0];
		stat = 8'h00;
		stat[STAT_BUSY] = s_r.busy;
		stat[STAT_WEL] = s_r.write_enable_latch;
		// pin samples pass two stages before use
		s_nxt.ck = {s_r.ck[1:0], link.sclk};
		s_nxt.cs = {s_r.cs[1:0], link.cs_n};
		s_nxt.io1 = link.io;
		s_nxt.io2 = s_r.io1;
		s_nxt.pw = 1'b0;
		if (s_r.busy) begin
			s_nxt.tmr = s_r.tmr + 16'h0001;
			if (s_r.tmr == 16'(PROG_CYCLES - 1)) begin
				s_nxt.busy = 1'b0;
				s_nxt.write_enable_latch = 1'b0;
			end
		end
		if (s_r.cs[1]) begin
			if (!s_r.cs[2] && s_r.st == S_PROG && s_r.cnt == 6'h00 && s_r.got && !s_r.busy
				&& !is_protected(s_r.addr, {protect_range_bit2, protect_range_bit1,
				protect_range_bit0}, protect_complement_bit, protect_granularity_bit,
				protect_top_bottom_bit, block_lock_map)) begin
				s_nxt.busy = 1'b1;
				s_nxt.tmr = 16'h0000;
				s_nxt.prog_base = s_r.addr[23:8];
			end
			s_nxt.st = S_IDLE;
			s_nxt.oe_n = 4'hF;
			s_nxt.cnt = 6'h00;
		end else if (s_r.st == S_IDLE) begin
			// armed continuous mode goes straight to the address
			s_nxt.st = s_r.crm ? S_ADDR : S_CMD;
			s_nxt.op = s_r.crm ? s_r.crm_op : s_r.op;
		end else if (rise) begin
			s_nxt.sh = sh_in;
			case (s_r.st)
				S_CMD: begin
					s_nxt.sh = {s_r.sh[30:0], s_r.io2[0]};
					s_nxt.cnt = s_r.cnt + 6'h01;
					if (s_r.cnt == 6'h07) begin
						b = {s_r.sh[6:0], s_r.io2[0]};
						s_nxt.op = b;
						s_nxt.cnt = 6'h00;
						s_nxt.st = S_IGN;
						s_nxt.reset_en = 1'b0;
						case (b)
							OP_WR_ENABLE: begin
								if (!s_r.busy) begin
									s_nxt.write_enable_latch = 1'b1;
								end
							end
							OP_STATUS: begin
								s_nxt.st = S_STAT;
							end
							OP_WRAP_SET: begin
								if (!s_r.busy && !four_line_command_mode) begin
									s_nxt.st = S_ADDR;
								end
							end
							OP_WORD_QREAD, OP_OCTAL_QREAD: begin
								if (!s_r.busy && quad_enable_bit) begin
									s_nxt.st = S_ADDR;
								end
							end
							OP_PROG: begin
								if (!s_r.busy && s_r.write_enable_latch) begin
									s_nxt.st = S_ADDR;
									s_nxt.pval = '0;
									s_nxt.got = 1'b0;
								end
							end
							OP_READ_PARAM: begin
								if (!s_r.busy && four_line_command_mode) begin
									s_nxt.st = S_MODE;
								end
							end
							OP_RESET_ENABLE: begin
								s_nxt.reset_en = 1'b1;
							end
							OP_RESET: begin
								if (s_r.reset_en && !s_r.busy) begin
									s_nxt.wrap_dis = WRAP_DIS_RST;
									s_nxt.wrap_len = WRAP_LEN_RST;
									s_nxt.write_enable_latch = 1'b0;
									s_nxt.crm = 1'b0;
								end
							end
							default: begin
							end
						endcase
					end
				end
				S_ADDR: begin
					s_nxt.cnt = s_r.cnt + (quad ? 6'h04 : 6'h01);
					if (s_nxt.cnt == ADDR_BITS) begin
						s_nxt.addr = sh_in[23:0];
						s_nxt.cnt = 6'h00;
						s_nxt.st = (s_r.op == OP_PROG) ? S_PROG : S_MODE;
					end
				end
				S_MODE: begin
					s_nxt.cnt = s_r.cnt + 6'h01;
					if (s_r.cnt == 6'h01) begin
						s_nxt.cnt = 6'h00;
						s_nxt.nib = 1'b0;
						s_nxt.st = S_IGN;
						if (s_r.op == OP_WRAP_SET) begin
							s_nxt.wrap_dis = b[WRAP_DIS_POS];
							s_nxt.wrap_len = b[WRAP_LEN_LO +: 2];
						end else if (s_r.op == OP_READ_PARAM) begin
							s_nxt.wrap_len = b[PARAM_LEN_LO +: 2];
						end else begin
							// low nibble of the mode byte is not looked at
							s_nxt.crm = (b[CRM_SEL_LO +: 2] == CRM_ARM);
							s_nxt.crm_op = s_r.op;
							s_nxt.st = (s_r.op == OP_OCTAL_QREAD) ? S_DATA : S_DUM;
						end
					end
				end
				S_DUM: begin
					s_nxt.cnt = s_r.cnt + 6'h01;
					if (s_r.cnt == WORD_DUMMY - 6'h01) begin
						s_nxt.st = S_DATA;
					end
				end
				S_PROG: begin
					s_nxt.cnt = s_r.cnt + 6'h01;
					if (s_r.cnt == 6'h07) begin
						s_nxt.cnt = 6'h00;
						s_nxt.got = 1'b1;
						s_nxt.pw = 1'b1;
						s_nxt.pw_idx = s_r.addr[7:0];
						s_nxt.pw_dat = sh_in[7:0];
						s_nxt.pval[s_r.addr[7:0]] = 1'b1;
						// only the low byte counts, so overflow lands at page start
						s_nxt.addr = {s_r.addr[23:8], s_r.addr[7:0] + 8'h01};
					end
				end
				default: begin
				end
			endcase
		end else if (fall) begin
			if (s_r.st == S_DATA) begin
				s_nxt.oe_n = 4'h0;
				s_nxt.nib = ~s_r.nib;
				if (!s_r.nib) begin
					s_nxt.dbyte = mem[s_r.addr[AW-1:0]];
					s_nxt.io_o = mem[s_r.addr[AW-1:0]][7:4];
				end else begin
					s_nxt.io_o = s_r.dbyte[3:0];
					s_nxt.addr = read_next(s_r.addr, s_r.op == OP_WORD_QREAD && !s_r.wrap_dis,
						s_r.wrap_len);
				end
			end else if (s_r.st == S_STAT) begin
				s_nxt.oe_n = 4'hD;
				s_nxt.io_o = {2'b00, stat[3'h7 - s_r.cnt[2:0]], 1'b0};
				s_nxt.cnt = {3'b000, s_r.cnt[2:0] + 3'h1};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.cs <= 3'h7;
			s_r.oe_n <= 4'hF;
			s_r.wrap_dis <= WRAP_DIS_RST;
			s_r.wrap_len <= WRAP_LEN_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign commit_addr = {s_r.prog_base, s_r.tmr[7:0]};

	// commit one page byte per cycle early in the timed cycle; array holds no reset
	always_ff @(posedge pclk) begin
		if (s_r.pw) begin
			pbuf[s_r.pw_idx] <= s_r.pw_dat;
		end
		if (s_r.busy && s_r.tmr[15:8] == 8'h00 && s_r.pval[s_r.tmr[7:0]]) begin
			mem[commit_addr[AW-1:0]] <= pbuf[s_r.tmr[7:0]];
		end
	end

	assign link.dev_io_o = s_r.io_o;
	assign link.dev_io_oe_n = s_r.oe_n;
	assign status_busy = s_r.busy;
	assign status_wel = s_r.write_enable_latch;
	assign wrap_disable_bit = s_r.wrap_dis;
	assign wrap_length_field = s_r.wrap_len;
	assign continuous_read_armed = s_r.crm;
endmodule : fwp_flash_dev

// File: fwp_spi_host.sv
// host controller end: apb registers drive one framed flash command
module fwp_spi_host import fwp_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	fwp_link_if.host link
);
	typedef struct packed {
		fwp_host_st_t st;
		logic [3:0] hc;
		logic sclk;
		logic cs_n;
		logic [3:0] io_o;
		logic [3:0] oe_n;
		logic [31:0] sh;
		logic [11:0] left;
		logic [3:0] q1;
		logic [3:0] q2;
		logic [31:0] rdata;
		logic [25:0] ctrl;
		logic [23:0] addr;
		logic [7:0] mode;
		logic [31:0] wdata;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic busy;
	} fwp_host_state_t;

	fwp_host_state_t s_r;
	fwp_host_state_t s_nxt;

	function automatic logic is_quad(fwp_host_st_t p, logic [25:0] c);
		return (p == H_ADDR && c[CF_ADDR_QUAD]) || p == H_MODE || (p == H_DATA && c[CF_DATA_QUAD]);
	endfunction : is_quad

	function automatic fwp_host_st_t after(fwp_host_st_t p, logic [25:0] c);
		if (p < H_OP && !c[CF_SKIP_OP]) begin
			return H_OP;
		end else if (p < H_ADDR && c[CF_ADDR_EN]) begin
			return H_ADDR;
		end else if (p < H_MODE && c[CF_MODE_EN]) begin
			return H_MODE;
		end else if (p < H_DUM && c[CF_DUMMY_LO +: 3] != 3'h0) begin
			return H_DUM;
		end else if (p < H_DATA && c[CF_NBYTES_LO +: 9] != 9'h000) begin
			return H_DATA;
		end
		return H_END;
	endfunction : after

	// shift pattern and clock count of a phase
	function automatic logic [43:0] load(fwp_host_st_t p, logic [25:0] c, logic [23:0] a,
		logic [7:0] m, logic [31:0] w);
		case (p)
			H_OP: return {c[7:0], 24'h00_0000, 12'h008};
			H_ADDR: return {a, 8'h00, c[CF_ADDR_QUAD] ? 12'h006 : 12'h018};
			H_MODE: return {m, 24'h00_0000, 12'h002};
			H_DUM: return {32'h0000_0000, 9'h000, c[CF_DUMMY_LO +: 3]};
			H_DATA: return {w, c[CF_DATA_QUAD] ? {2'b00, c[CF_NBYTES_LO +: 9], 1'b0}
				: {c[CF_NBYTES_LO +: 9], 3'b000}};
			default: return 44'h000_0000_0000;
		endcase
	endfunction : load

	always_comb begin
		logic q;
		logic wr_go;
		fwp_host_st_t np;
		s_nxt = s_r;
		q = is_quad(s_r.st, s_r.ctrl);
		np = H_IDLE;
		s_nxt.q1 = link.io;
		s_nxt.q2 = s_r.q1;
		// apb: setup cycle prepares the answer, access cycle carries pready
		s_nxt.pready = psel & ~penable;
		s_nxt.pslverr = 1'b0;
		s_nxt.prdata = 32'h0000_0000;
		if (psel && !penable) begin
			if (paddr == REG_CTRL) begin
				s_nxt.prdata = {6'h00, s_r.ctrl};
			end else if (paddr == REG_ADDR) begin
				s_nxt.prdata = {8'h00, s_r.addr};
			end else if (paddr == REG_MODE) begin
				s_nxt.prdata = {24'h00_0000, s_r.mode};
			end else if (paddr == REG_WDATA) begin
				s_nxt.prdata = s_r.wdata;
			end else if (paddr == REG_RDATA) begin
				s_nxt.prdata = s_r.rdata;
			end else if (paddr == REG_STATUS) begin
				s_nxt.prdata = {31'h0000_0000, s_r.busy};
			end else begin
				s_nxt.pslverr = 1'b1;
			end
		end
		wr_go = psel & penable & pwrite & s_r.pready;
		if (wr_go && paddr == REG_ADDR) begin
			s_nxt.addr = pwdata[23:0];
		end else if (wr_go && paddr == REG_MODE) begin
			s_nxt.mode = pwdata[7:0];
		end else if (wr_go && paddr == REG_WDATA) begin
			s_nxt.wdata = pwdata;
		end
		// a new command while one runs is dropped
		if (wr_go && paddr == REG_CTRL && !s_r.busy) begin
			s_nxt.ctrl = pwdata[25:0];
			if (pwdata[CF_START]) begin
				np = after(H_IDLE, pwdata[25:0]);
				s_nxt.busy = 1'b1;
				s_nxt.cs_n = 1'b0;
				s_nxt.sclk = 1'b0;
				s_nxt.hc = 4'h0;
				s_nxt.st = np;
				{s_nxt.sh, s_nxt.left} = load(np, pwdata[25:0], s_r.addr, s_r.mode, s_r.wdata);
			end
		end else if (s_r.st == H_END) begin
			s_nxt.hc = s_r.hc + 4'h1;
			if (s_r.hc == 4'(SCK_HALF - 1)) begin
				s_nxt.st = H_IDLE;
				s_nxt.busy = 1'b0;
			end
		end else if (s_r.st != H_IDLE) begin
			s_nxt.hc = s_r.hc + 4'h1;
			if (s_r.hc == 4'(SCK_HALF - 1)) begin
				s_nxt.hc = 4'h0;
				s_nxt.sclk = ~s_r.sclk;
				if (!s_r.sclk) begin
					s_nxt.left = s_r.left - 12'h001;
					if (s_r.st == H_DATA && !s_r.ctrl[CF_WRITE]) begin
						s_nxt.rdata = q ? {s_r.rdata[27:0], s_r.q2} : {s_r.rdata[30:0], s_r.q2[1]};
					end
				end else if (s_r.left == 12'h000) begin
					// phases end as the clock falls, so deselect comes with the last clock fall
					np = after(s_r.st, s_r.ctrl);
					s_nxt.st = np;
					s_nxt.cs_n = (np == H_END);
					{s_nxt.sh, s_nxt.left} = load(np, s_r.ctrl, s_r.addr, s_r.mode, s_r.wdata);
				end else begin
					s_nxt.sh = q ? {s_r.sh[27:0], s_r.sh[31:28]} : {s_r.sh[30:0], s_r.sh[31]};
				end
			end
		end
		q = is_quad(s_nxt.st, s_nxt.ctrl);
		s_nxt.io_o = q ? s_nxt.sh[31:28] : {3'b000, s_nxt.sh[31]};
		if (s_nxt.st == H_IDLE || s_nxt.st == H_END || s_nxt.st == H_DUM
			|| (s_nxt.st == H_DATA && !s_nxt.ctrl[CF_WRITE])) begin
			s_nxt.oe_n = 4'hF;
		end else begin
			s_nxt.oe_n = q ? 4'h0 : 4'hE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.cs_n <= 1'b1;
			s_r.oe_n <= 4'hF;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign link.cs_n = s_r.cs_n;
	assign link.sclk = s_r.sclk;
	assign link.host_io_o = s_r.io_o;
	assign link.host_io_oe_n = s_r.oe_n;
endmodule : fwp_spi_host

// File: fwp_link_props.sv
// link checker: framing, pacing and line ownership between the two ends
module fwp_link_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] host_io_o,
	input wire logic [3:0] host_io_oe_n,
	input wire logic [3:0] dev_io_o,
	input wire logic [3:0] dev_io_oe_n,
	input wire logic [3:0] io
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_no_fight: assert property ((host_io_oe_n | dev_io_oe_n) == 4'hf)
		else $error("both ends drive one line");
	a_sclk_idle: assert property (cs_n |-> !sclk)
		else $error("serial clock moves while deselected");
	a_first_rise: assert property ($fell(cs_n) |-> (!sclk) [*8] ##1 sclk)
		else $error("first clock rise not eight cycles after select");
	a_half_high: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
		else $error("serial clock high phase off");
	a_host_hold: assert property (sclk && $past(sclk) |-> $stable(host_io_o) && $stable(host_io_oe_n))
		else $error("host line moved while clock high");
	a_end_low: assert property ($rose(cs_n) |-> $past(sclk) && !sclk)
		else $error("deselect not on the last clock fall");
	// sync lag of two cycles plus one register, so six is safe
	a_dev_quiet: assert property (cs_n [*6] |-> dev_io_oe_n == 4'hf)
		else $error("device drives while deselected");
	a_dev_hold: assert property (sclk && $past(sclk) && dev_io_oe_n != 4'hf |-> $stable(dev_io_o))
		else $error("device data moved while clock high");
	a_op_listen: assert property ($fell(cs_n) |-> (dev_io_oe_n == 4'hf) [*8])
		else $error("device drives at frame start");
endmodule : fwp_link_props

// File: test_flash_wrap_read_page_program.sv
// bench: host and device joined on one link, host reached over apb
module test_flash_wrap_read_page_program import fwp_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [23:0] PG = 24'h00_0f00;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = '0, m;
	logic [31:0] pwdata = '0, prdata, q;
	logic pready, pslverr, e, qe = 1, fl4 = 0, busy, write_enable_latch, wdis, armed;
	logic [1:0] wlen;
	logic [5:0] prot = '0;
	logic [63:0] lock = '0;
	logic [7:0] pg [256];
	int miscompares = 0, checks_done = 0, cyc = 0, l, s, n;
	always #2.5 pclk = ~pclk;
	fwp_link_if link_bus ();
	fwp_spi_host i_fwp_spi_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link_bus.host));
	// short program time keeps the run small; must stay at least 256
	fwp_flash_dev #(.PROG_CYCLES(1000)) i_fwp_flash_dev (.pclk(pclk), .presetn(presetn),
		.link(link_bus.dev), .quad_enable_bit(qe), .four_line_command_mode(fl4),
		.protect_complement_bit(prot[5]), .protect_granularity_bit(prot[4]),
		.protect_top_bottom_bit(prot[3]), .protect_range_bit2(prot[2]),
		.protect_range_bit1(prot[1]), .protect_range_bit0(prot[0]), .block_lock_map(lock),
		.status_busy(busy), .status_wel(write_enable_latch), .wrap_disable_bit(wdis),
		.wrap_length_field(wlen), .continuous_read_armed(armed));
	fwp_link_props i_fwp_link_props (.pclk(pclk), .presetn(presetn), .cs_n(link_bus.cs_n),
		.sclk(link_bus.sclk), .host_io_o(link_bus.host_io_o), .host_io_oe_n(link_bus.host_io_oe_n),
		.dev_io_o(link_bus.dev_io_o), .dev_io_oe_n(link_bus.dev_io_oe_n), .io(link_bus.io));
	task automatic finish_test();
		$display("checks %0d, miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [63:0] g, input logic [63:0] x);
		checks_done++;
		if (g !== x) begin
			miscompares++;
			$display("unexpected at %0t: got %h, expected %h", $time, g, x);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// one framed command; waits for the host to go idle again
	task automatic cmd(input logic [7:0] op, input logic [8:0] f, input int c,
		input logic [23:0] a, input logic [7:0] md, input logic [31:0] d);
		apb(1'b1, REG_ADDR, {8'h00, a});
		apb(1'b1, REG_MODE, {24'h00_0000, md});
		apb(1'b1, REG_WDATA, d);
		apb(1'b1, REG_CTRL, {1'b1, 5'h00, c[8:0], f, op});
		do apb(1'b0, REG_STATUS, 32'h0); while (q[0] !== 1'b0);
		repeat (8) @(posedge pclk);
	endtask : cmd
	task automatic rd(input logic [7:0] op, input logic [8:0] f, input int c, input int so,
		input logic [7:0] md);
		cmd(op, f, c, {PG[23:8], so[7:0]}, md, 32'h0);
		apb(1'b0, REG_RDATA, 32'h0);
	endtask : rd
	// last four bytes of a read of c bytes from page offset so; wl 0 means linear
	function automatic logic [31:0] ex(input int so, input int c, input int wl);
		logic [31:0] r;
		int o;
		r = '0;
		for (int k = c - 4; k < c; k++) begin
			o = (wl != 0) ? ((so & ~(wl - 1)) | ((so + k) % wl)) : so + k;
			r = {r[23:0], pg[o[7:0]]};
		end
		return r;
	endfunction : ex
	task automatic prog(input logic [7:0] so, input int c, input logic we, input logic ok);
		logic [31:0] d;
		d = $urandom;
		if (we) cmd(OP_WR_ENABLE, 9'h000, 0, 24'h0, 8'h00, 32'h0);
		cmd(OP_PROG, 9'h082, c, {PG[23:8], so}, 8'h00, d);
		chk(busy, ok);
		if (ok) begin
			for (int k = 0; k < c; k++) pg[8'(so + k)] = d[31 - 8 * (k % 4) -: 8];
			cmd(OP_STATUS, 9'h000, 1, 24'h0, 8'h00, 32'h0);
			apb(1'b0, REG_RDATA, 32'h0);
			chk(q[7:0], 8'h03);
			for (int i = 0; i < 1200 && busy === 1'b1; i++) @(posedge pclk);
			chk({busy, write_enable_latch}, 2'b00);
		end
	endtask : prog
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 90000) begin
			miscompares++;
			finish_test();
		end
	end
	initial begin
		q = $urandom(32'h27dc_f0f1);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		chk({busy, write_enable_latch, wdis, wlen}, 5'b00100);
		apb(1'b0, 8'h40, 32'h0);
		chk({e, q}, {1'b1, 32'h0});
		prog(8'hc0, 4, 1'b0, 1'b0);
		for (int i = 0; i < 8; i++) prog(8'(8'hc0 + 8 * i), 8, 1'b1, 1'b1);
		prog(8'hfc, 8, 1'b1, 1'b1);
		for (int i = 0; i < 4; i++) begin
			lock <= (i == 0) ? 64'h1 : 64'h0;
			prot <= (i == 0) ? 6'h00 : (i == 1) ? 6'h09 : (i == 2) ? 6'h19 : 6'h20;
			prog(8'hc0, 4, 1'b1, 1'b0);
			chk(write_enable_latch, 1'b1);
		end
		lock <= '0;
		prot <= '0;
		// five bytes on four lines end the frame two bits past a byte edge
		cmd(OP_PROG, 9'h182, 5, {PG[23:8], 8'hc0}, 8'h00, 32'h0);
		chk({busy, write_enable_latch}, 2'b01);
		rd(OP_WORD_QREAD, 9'h12e, 4, 0, 8'h00);
		chk(q, ex(0, 4, 0));
		qe <= 1'b0;
		rd(OP_OCTAL_QREAD, 9'h10e, 4, 8'hd0, 8'h00);
		chk(q, 32'hffff_ffff);
		qe <= 1'b1;
		rd(OP_OCTAL_QREAD, 9'h10e, 4, 8'hd0, 8'h00);
		chk(q, ex(8'hd0, 4, 0));
		// shortest section last, so the linear read after it tells the two apart
		for (int i = 3; i >= 0; i--) begin
			l = 8 << i;
			m = (8'($urandom) & 8'h8f) | {1'b0, 2'(i), 5'h00};
			cmd(OP_WRAP_SET, 9'h00e, 0, 24'($urandom), m, 32'h0);
			chk({wdis, wlen}, {1'b0, 2'(i)});
			s = 256 - l + 2 * int'($urandom % (l / 2 - 1));
			n = l - s % l + 2;
			rd(OP_WORD_QREAD, 9'h12e, n, s, 8'h00);
			chk(q, ex(s, n, l));
		end
		cmd(OP_WRAP_SET, 9'h00e, 0, 24'h0, 8'h10, 32'h0);
		chk({wdis, wlen}, 3'b100);
		rd(OP_WORD_QREAD, 9'h12e, 8, 8'hdc, 8'h00);
		chk(q, ex(8'hdc, 8, 0));
		rd(OP_WORD_QREAD, 9'h12e, 4, 8'he0, {4'ha, 4'($urandom)});
		chk({armed, q}, {1'b1, ex(8'he0, 4, 0)});
		rd(OP_WORD_QREAD, 9'h12f, 4, 8'he8, 8'hff);
		chk({armed, q}, {1'b0, ex(8'he8, 4, 0)});
		rd(OP_WORD_QREAD, 9'h12e, 4, 8'hf0, 8'h20);
		chk({armed, q}, {1'b1, ex(8'hf0, 4, 0)});
		// opcode of ones lands in the mode slot and forces bit 4 high
		cmd(8'hff, 9'h000, 0, 24'h0, 8'h00, 32'h0);
		chk(armed, 1'b0);
		cmd(OP_WRAP_SET, 9'h00e, 0, 24'h0, 8'h20, 32'h0);
		cmd(OP_RESET_ENABLE, 9'h000, 0, 24'h0, 8'h00, 32'h0);
		cmd(OP_RESET, 9'h000, 0, 24'h0, 8'h00, 32'h0);
		chk({wdis, wlen}, 3'b100);
		cmd(OP_READ_PARAM, 9'h008, 0, 24'h0, 8'h03, 32'h0);
		chk(wlen, 2'b00);
		fl4 <= 1'b1;
		cmd(OP_WRAP_SET, 9'h00e, 0, 24'h0, 8'h60, 32'h0);
		chk(wdis, 1'b1);
		cmd(OP_READ_PARAM, 9'h008, 0, 24'h0, 8'h02, 32'h0);
		chk(wlen, 2'b10);
		fl4 <= 1'b0;
		finish_test();
	end
endmodule : test_flash_wrap_read_page_program
